// ---- rtl/ldc_consts.vh ----
`ifndef LDC_CONSTS_VH
`define LDC_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LDC_ADDR_SEQ_SLOTS_3_4 8'h21
`define LDC_ADDR_SEQ_SLOTS_5_6 8'h22
`define LDC_ADDR_EMITTER1_CODE 8'h23
`define LDC_ADDR_EMITTER2_CODE 8'h24
`define LDC_ADDR_EMITTER3_CODE 8'h25
`define LDC_ADDR_PROBE_CODE 8'h29
`define LDC_ADDR_FULLSCALE 8'h2A
`define LDC_ADDR_EXPOSURE1_DAC 8'h2C

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define LDC_RESET_BYTE 8'h00
`define LDC_RESET_RANGE 2'h0
`define LDC_RESET_DAC_CODE 6'h00
`define LDC_FULLSCALE_MASK 8'h3F
`define LDC_DAC_MASK 8'hBF
`define LDC_DAC_OVR_BIT 7
`define LDC_EMITTER1_RANGE_LSB 0
`define LDC_EMITTER2_RANGE_LSB 2
`define LDC_EMITTER3_RANGE_LSB 4

// ----------------------------------------
// Step current in microamps per code, by range
// ----------------------------------------
`define LDC_STEP_UA_R0 10'h078
`define LDC_STEP_UA_R1 10'h0F0
`define LDC_STEP_UA_R2 10'h168
`define LDC_STEP_UA_R3 10'h1E0

`endif

// ---- rtl/ldc_led_drive_config_regs.v ----
// Operation
// - Two sequence registers hold slot 3-6 types
// - Emitter 1 drive code, 8-bit, resets zero
// - Current is code times range step size
// - Emitter 2 drive code, same mapping
// - Emitter 3 drive code, same mapping
// - Probe code replaces codes in probe/multi modes
// - Probe code scaled by that emitter's range
// - Range selects 30.6, 61.2, 91.8, 122.4 mA at code 255
// - Range fields at bits 1:0, 3:2, 5:4
// - DAC register: override bit 7, code 5:0
// - Override selects stored code, else chip's
`timescale 1ns/1ps
`include "ldc_consts.vh"

module ldc_led_drive_config_regs (
  // Clock and reset
  input wire clk_sys,
  input wire rst,
  // Register access port
  input wire reg_wr,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  // Operating mode from sequencer
  input wire probe_mode,
  input wire multi_emitter_mode,
  // Slot types to the sample FIFO
  output wire [3:0] slot3_type,
  output wire [3:0] slot4_type,
  output wire [3:0] slot5_type,
  output wire [3:0] slot6_type,
  // Emitter drivers
  output wire [7:0] emitter1_drive,
  output wire [7:0] emitter2_drive,
  output wire [7:0] emitter3_drive,
  output wire [1:0] emitter1_fullscale,
  output wire [1:0] emitter2_fullscale,
  output wire [1:0] emitter3_fullscale,
  output wire [17:0] emitter1_current_ua,
  output wire [17:0] emitter2_current_ua,
  output wire [17:0] emitter3_current_ua,
  // Exposure 1 subranging DAC
  input wire [5:0] chip_dac_code,
  output wire exposure1_dac_override,
  output wire [5:0] exposure1_dac_drive
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg [7:0] seq_slots_3_4;
  reg [7:0] seq_slots_5_6;
  reg [7:0] emitter1_code;
  reg [7:0] emitter2_code;
  reg [7:0] emitter3_code;
  reg [7:0] probe_code;
  reg [7:0] emitter_fullscale_select;
  reg [7:0] exposure1_subrange_dac;

  // ----------------------------------------
  // Next values
  // ----------------------------------------
  reg [7:0] next_seq_slots_3_4;
  reg [7:0] next_seq_slots_5_6;
  reg [7:0] next_emitter1_code;
  reg [7:0] next_emitter2_code;
  reg [7:0] next_emitter3_code;
  reg [7:0] next_probe_code;
  reg [7:0] next_emitter_fullscale_select;
  reg [7:0] next_exposure1_subrange_dac;
  reg [7:0] next_reg_rdata;

  // ----------------------------------------
  // Decode signals
  // ----------------------------------------
  wire hit_seq_slots_3_4;
  wire hit_seq_slots_5_6;
  wire hit_emitter1_code;
  wire hit_emitter2_code;
  wire hit_emitter3_code;
  wire hit_probe_code;
  wire hit_fullscale;
  wire hit_exposure1_dac;
  wire use_probe;

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function ldc_addr_hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      ldc_addr_hit = (addr == target);
    end
  endfunction

  // Step per code in microamps; the analog side owns the exact trim
  function [9:0] ldc_step_ua;
    input [1:0] range;
    begin
      case (range)
        2'h0: ldc_step_ua = `LDC_STEP_UA_R0;
        2'h1: ldc_step_ua = `LDC_STEP_UA_R1;
        2'h2: ldc_step_ua = `LDC_STEP_UA_R2;
        default: ldc_step_ua = `LDC_STEP_UA_R3;
      endcase
    end
  endfunction

  // Code 255 at the top range needs 17 bits, so 18 leaves headroom
  function [17:0] ldc_current_ua;
    input [7:0] code;
    input [1:0] range;
    begin
      ldc_current_ua = {10'h000, code} * {8'h00, ldc_step_ua(range)};
    end
  endfunction

  // Probe code replaces the own code; the caller keeps its own range
  function [7:0] ldc_pick_code;
    input sel_probe;
    input [7:0] probe;
    input [7:0] own;
    begin
      if (sel_probe) begin
        ldc_pick_code = probe;
      end else begin
        ldc_pick_code = own;
      end
    end
  endfunction

  // ----------------------------------------
  // Address match
  // ----------------------------------------
  assign hit_seq_slots_3_4 = ldc_addr_hit(reg_addr, `LDC_ADDR_SEQ_SLOTS_3_4);
  assign hit_seq_slots_5_6 = ldc_addr_hit(reg_addr, `LDC_ADDR_SEQ_SLOTS_5_6);
  assign hit_emitter1_code = ldc_addr_hit(reg_addr, `LDC_ADDR_EMITTER1_CODE);
  assign hit_emitter2_code = ldc_addr_hit(reg_addr, `LDC_ADDR_EMITTER2_CODE);
  assign hit_emitter3_code = ldc_addr_hit(reg_addr, `LDC_ADDR_EMITTER3_CODE);
  assign hit_probe_code = ldc_addr_hit(reg_addr, `LDC_ADDR_PROBE_CODE);
  assign hit_fullscale = ldc_addr_hit(reg_addr, `LDC_ADDR_FULLSCALE);
  assign hit_exposure1_dac = ldc_addr_hit(reg_addr, `LDC_ADDR_EXPOSURE1_DAC);

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Held unless strobed; reserved bits are cleared on the way in
  always @* begin
    next_seq_slots_3_4 = seq_slots_3_4;
    next_seq_slots_5_6 = seq_slots_5_6;
    next_emitter1_code = emitter1_code;
    next_emitter2_code = emitter2_code;
    next_emitter3_code = emitter3_code;
    next_probe_code = probe_code;
    next_emitter_fullscale_select = emitter_fullscale_select;
    next_exposure1_subrange_dac = exposure1_subrange_dac;
    if (reg_wr) begin
      if (hit_seq_slots_3_4) begin
        next_seq_slots_3_4 = reg_wdata;
      end
      if (hit_seq_slots_5_6) begin
        next_seq_slots_5_6 = reg_wdata;
      end
      if (hit_emitter1_code) begin
        next_emitter1_code = reg_wdata;
      end
      if (hit_emitter2_code) begin
        next_emitter2_code = reg_wdata;
      end
      if (hit_emitter3_code) begin
        next_emitter3_code = reg_wdata;
      end
      if (hit_probe_code) begin
        next_probe_code = reg_wdata;
      end
      if (hit_fullscale) begin
        next_emitter_fullscale_select = reg_wdata & `LDC_FULLSCALE_MASK;
      end
      if (hit_exposure1_dac) begin
        next_exposure1_subrange_dac = reg_wdata & `LDC_DAC_MASK;
      end
    end
  end

  // One process per register keeps each reset path plain
  always @(posedge clk_sys) begin
    if (rst) begin
      seq_slots_3_4 <= `LDC_RESET_BYTE;
    end else begin
      seq_slots_3_4 <= next_seq_slots_3_4;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      seq_slots_5_6 <= `LDC_RESET_BYTE;
    end else begin
      seq_slots_5_6 <= next_seq_slots_5_6;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      emitter1_code <= `LDC_RESET_BYTE;
    end else begin
      emitter1_code <= next_emitter1_code;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      emitter2_code <= `LDC_RESET_BYTE;
    end else begin
      emitter2_code <= next_emitter2_code;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      emitter3_code <= `LDC_RESET_BYTE;
    end else begin
      emitter3_code <= next_emitter3_code;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      probe_code <= `LDC_RESET_BYTE;
    end else begin
      probe_code <= next_probe_code;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      emitter_fullscale_select <= `LDC_RESET_BYTE;
    end else begin
      emitter_fullscale_select <= next_emitter_fullscale_select;
    end
  end

  always @(posedge clk_sys) begin
    if (rst) begin
      exposure1_subrange_dac <= `LDC_RESET_BYTE;
    end else begin
      exposure1_subrange_dac <= next_exposure1_subrange_dac;
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Mask again on read so a reserved bit can never leak out
  always @* begin
    case (reg_addr)
      `LDC_ADDR_SEQ_SLOTS_3_4: next_reg_rdata = seq_slots_3_4;
      `LDC_ADDR_SEQ_SLOTS_5_6: next_reg_rdata = seq_slots_5_6;
      `LDC_ADDR_EMITTER1_CODE: next_reg_rdata = emitter1_code;
      `LDC_ADDR_EMITTER2_CODE: next_reg_rdata = emitter2_code;
      `LDC_ADDR_EMITTER3_CODE: next_reg_rdata = emitter3_code;
      `LDC_ADDR_PROBE_CODE: next_reg_rdata = probe_code;
      `LDC_ADDR_FULLSCALE: next_reg_rdata = emitter_fullscale_select & `LDC_FULLSCALE_MASK;
      `LDC_ADDR_EXPOSURE1_DAC: next_reg_rdata = exposure1_subrange_dac & `LDC_DAC_MASK;
      default: next_reg_rdata = `LDC_RESET_BYTE;
    endcase
  end

  // Registered so read data never glitches with address
  always @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= `LDC_RESET_BYTE;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  assign slot3_type = seq_slots_3_4[3:0];
  assign slot4_type = seq_slots_3_4[7:4];
  assign slot5_type = seq_slots_5_6[3:0];
  assign slot6_type = seq_slots_5_6[7:4];

  assign emitter1_fullscale = emitter_fullscale_select[`LDC_EMITTER1_RANGE_LSB +: 2];
  assign emitter2_fullscale = emitter_fullscale_select[`LDC_EMITTER2_RANGE_LSB +: 2];
  assign emitter3_fullscale = emitter_fullscale_select[`LDC_EMITTER3_RANGE_LSB +: 2];

  // Probe code overrides all emitters; range stays per emitter
  assign use_probe = probe_mode | multi_emitter_mode;
  assign emitter1_drive = ldc_pick_code(use_probe, probe_code, emitter1_code);
  assign emitter2_drive = ldc_pick_code(use_probe, probe_code, emitter2_code);
  assign emitter3_drive = ldc_pick_code(use_probe, probe_code, emitter3_code);

  assign emitter1_current_ua = ldc_current_ua(emitter1_drive, emitter1_fullscale);
  assign emitter2_current_ua = ldc_current_ua(emitter2_drive, emitter2_fullscale);
  assign emitter3_current_ua = ldc_current_ua(emitter3_drive, emitter3_fullscale);

  assign exposure1_dac_override = exposure1_subrange_dac[`LDC_DAC_OVR_BIT];
  assign exposure1_dac_drive = exposure1_dac_override ? exposure1_subrange_dac[5:0] : chip_dac_code;

endmodule

// ---- verif/ldc_props.sv ----
`timescale 1ns/1ps
module ldc_props (
  input wire clk_sys, rst, reg_wr, probe_mode, multi_emitter_mode, exposure1_dac_override,
  input wire [7:0] reg_addr, reg_wdata, reg_rdata, emitter1_drive, emitter2_drive,
  input wire [1:0] emitter1_fullscale,
  input wire [17:0] emitter1_current_ua,
  input wire [5:0] chip_dac_code, exposure1_dac_drive
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire pm = probe_mode || multi_emitter_mode;
  a_drive_write: assert property (reg_wr && reg_addr == 8'h23 && !pm ##1 !pm |-> emitter1_drive == $past(reg_wdata))
    else $error("drive");
  a_probe_share: assert property (pm |-> emitter1_drive == emitter2_drive) else $error("probe");
  a_step_scale: assert property (emitter1_current_ua == emitter1_drive * (emitter1_fullscale + 18'd1) * 18'd120)
    else $error("step");
  a_range_write: assert property (reg_wr && reg_addr == 8'h2A |=> emitter1_fullscale == ($past(reg_wdata) & 8'h03))
    else $error("range");
  a_range_mask: assert property (reg_addr == 8'h2A |=> reg_rdata[7:6] == 2'h0) else $error("rmask");
  a_chip_dac: assert property (!exposure1_dac_override |-> exposure1_dac_drive == chip_dac_code) else $error("chip");
  a_dac_write: assert property (reg_wr && reg_addr == 8'h2C && reg_wdata[7] |=> exposure1_dac_override &&
    exposure1_dac_drive == ($past(reg_wdata) & 8'h3F)) else $error("dac");
  a_dac_mask: assert property (reg_addr == 8'h2C |=> !reg_rdata[6]) else $error("dmask");
  cover property (reg_wr && reg_addr == 8'h2C && reg_wdata[7]);
  cover property (probe_mode && emitter1_fullscale == 2'h3);
  cover property (multi_emitter_mode && !probe_mode);
endmodule
bind ldc_led_drive_config_regs ldc_props u_props (
  .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .probe_mode(probe_mode),
  .multi_emitter_mode(multi_emitter_mode), .exposure1_dac_override(exposure1_dac_override),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .emitter1_drive(emitter1_drive),
  .emitter2_drive(emitter2_drive), .emitter1_fullscale(emitter1_fullscale),
  .emitter1_current_ua(emitter1_current_ua), .chip_dac_code(chip_dac_code),
  .exposure1_dac_drive(exposure1_dac_drive));

// ---- verif/ldc_led_drive_config_regs_tb_top.sv ----
`timescale 1ns/1ps
module ldc_led_drive_config_regs_tb_top;
  reg clk_sys = 0, rst = 1, reg_wr = 0, probe_mode = 0, multi_emitter_mode = 0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rv;
  reg [5:0] chip_dac_code = 6'h2A;
  wire [3:0] slot3_type, slot4_type, slot5_type, slot6_type;
  wire [7:0] reg_rdata, emitter1_drive, emitter2_drive, emitter3_drive;
  wire [1:0] emitter1_fullscale, emitter2_fullscale, emitter3_fullscale;
  wire [17:0] emitter1_current_ua, emitter2_current_ua, emitter3_current_ua;
  wire exposure1_dac_override;
  wire [5:0] exposure1_dac_drive;
  integer miscompares = 0, n_tests = 0, cyc = 0, i;
  reg [23:0] rows [0:8];
  ldc_led_drive_config_regs dut_u (
    .clk_sys(clk_sys), .rst(rst), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .probe_mode(probe_mode), .multi_emitter_mode(multi_emitter_mode),
    .slot3_type(slot3_type), .slot4_type(slot4_type), .slot5_type(slot5_type), .slot6_type(slot6_type),
    .emitter1_drive(emitter1_drive), .emitter2_drive(emitter2_drive), .emitter3_drive(emitter3_drive),
    .emitter1_fullscale(emitter1_fullscale), .emitter2_fullscale(emitter2_fullscale),
    .emitter3_fullscale(emitter3_fullscale), .emitter1_current_ua(emitter1_current_ua),
    .emitter2_current_ua(emitter2_current_ua), .emitter3_current_ua(emitter3_current_ua),
    .chip_dac_code(chip_dac_code), .exposure1_dac_override(exposure1_dac_override),
    .exposure1_dac_drive(exposure1_dac_drive));
  initial forever #5 clk_sys = ~clk_sys;
  task chk(input [35:0] got, input [35:0] want);
    begin
      n_tests = n_tests + 1;
      if (got !== want) begin
        miscompares = miscompares + 1;
        $display("ERROR %0t got %h want %h", $time, got, want);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
      @(negedge clk_sys) reg_wr = 0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(negedge clk_sys) reg_addr = a;
      @(negedge clk_sys) rv = reg_rdata;
    end
  endtask
  task close_out;
    begin
      $display("miscompares %0d n_tests %0d", miscompares, n_tests);
      if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // Generous ceiling: the sequence needs under 100 cycles
  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 400) begin
      miscompares = miscompares + 1;
      close_out;
    end
  end
  initial begin
    rows[0] = 24'h21A5A5;
    rows[1] = 24'h223C3C;
    rows[2] = 24'h230505;
    rows[3] = 24'h24FFFF;
    rows[4] = 24'h258080;
    rows[5] = 24'h291111;
    rows[6] = 24'h2AFF3F;
    rows[7] = 24'h2CFFBF;
    rows[8] = 24'h265500;
    repeat (2) @(negedge clk_sys);
    rst = 0;
    rd(8'h2A);
    chk(rv, 8'h00);
    for (i = 0; i < 9; i = i + 1) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rd(rows[i][23:16]);
      chk(rv, rows[i][7:0]);
    end
    chk({slot6_type, slot5_type, slot4_type, slot3_type}, 16'h3CA5);
    chk(emitter1_current_ua, 18'd2400);
    chk(exposure1_dac_drive, 6'h3F);
    chk({exposure1_dac_override, emitter3_drive, emitter2_drive, emitter1_drive}, 25'h180FF05);
    @(negedge clk_sys) chip_dac_code = 6'h15;
    #1 chk(exposure1_dac_drive, 6'h3F);
    wr(8'h2A, 8'h24);
    chk({emitter3_fullscale, emitter2_fullscale, emitter1_fullscale}, 6'h24);
    chk({emitter3_current_ua, emitter2_current_ua}, {18'd46080, 18'd61200});
    @(negedge clk_sys) probe_mode = 1;
    #1 chk({emitter3_current_ua, emitter2_current_ua}, {18'd6120, 18'd4080});
    chk({emitter3_drive, emitter2_drive, emitter1_drive}, 24'h111111);
    @(negedge clk_sys) {probe_mode, multi_emitter_mode} = 2'b01;
    #1 chk(emitter1_current_ua, 18'd2040);
    @(negedge clk_sys) multi_emitter_mode = 0;
    wr(8'h2C, 8'h40);
    rd(8'h2C);
    chk({rv, exposure1_dac_override, exposure1_dac_drive}, {8'h00, 1'b0, 6'h15});
    @(negedge clk_sys) rst = 1;
    @(negedge clk_sys) rst = 0;
    rd(8'h24);
    chk(rv, 8'h00);
    chk({emitter3_fullscale, emitter2_fullscale, slot4_type, emitter3_drive}, 16'h0000);
    close_out;
  end
endmodule
